// ### bench/count_pair_ext_clk.sv
// Far side of the count clock pins: external input and aux oscillator.
// Assumes edges slow enough for the two-flop synchroniser of the timer.
`timescale 1ns/1ps
module count_pair_ext_clk (
  // Count clock lines
  output logic ext_count_input,
  output logic aux_osc_clk
);
  initial begin
    ext_count_input = 1'b0;
    aux_osc_clk = 1'b0;
  end

  // Lines stand low between bursts; period unrelated to clk
  task automatic pulses(input int n, input bit aux);
    repeat (n) begin
      #80;
      {aux_osc_clk, ext_count_input} = aux ? 2'h2 : 2'h1;
      #80;
      {aux_osc_clk, ext_count_input} = 2'h0;
    end
  endtask
endmodule // count_pair_ext_clk

// ### bench/count_pair_top_tb.sv
// Self-checking bench of the timer top with its count clock partner.
// Assumes the constants header and the package are compiled first.
`timescale 1ns/1ps
`include "count_pair_consts.svh"
module count_pair_top_tb;
  import count_pair_pkg::*;
  localparam logic [7:0] A_CT = `COUNT_PAIR_OFS_CTRL;
  localparam logic [7:0] A_LO = `COUNT_PAIR_OFS_CNT_LO;
  localparam logic [7:0] A_HI = `COUNT_PAIR_OFS_CNT_HI;
  localparam logic [7:0] A_FL = `COUNT_PAIR_OFS_FLAGS;
  localparam logic [7:0] A_EN = `COUNT_PAIR_OFS_ENABLES;
  localparam logic [7:0] A_PR = `COUNT_PAIR_OFS_PRIO;
  localparam logic [7:0] A_AX = `COUNT_PAIR_OFS_AUX;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, compare_value_high, compare_value_low, v;
  logic [31:0] pwdata, prdata;
  logic ext_count_input, aux_osc_clk, compare_trigger, trig_req;
  logic overflow_irq, overflow_irq_high_prio;
  logic [1:0] port_direction, osc_pin_oe_n;
  logic [3:0] compare_unit_mode_field;
  logic [15:0] count_value;
  count_pair_mode_type count_mode;
  logic [32:0] exp_q[$];
  int n_errors, comparisons;

  count_pair_top count_pair_top_i (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_count_input, .aux_osc_clk,
    .port_direction, .osc_pin_oe_n, .compare_unit_mode_field,
    .compare_trigger, .compare_value_high, .compare_value_low, .count_mode,
    .count_value, .overflow_irq, .overflow_irq_high_prio);
  count_pair_ext_clk count_pair_ext_clk_i (.ext_count_input, .aux_osc_clk);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ***************************************
  // Checking and bus tasks
  // ***************************************
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    compare_trigger <= trig_req;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    compare_trigger <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      $display("wrong value at %0t: no pready", $time);
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({25'h0, e});
    apb(1'b0, a, 8'h00);
  endtask

  // Narrow mode: high byte goes straight into the count; wide mode buffers it until the low write
  task automatic cnt(input logic [15:0] c);
    apb(1'b1, A_HI, c[15:8]);
    apb(1'b1, A_LO, c[7:0]);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic cv(input logic [15:0] e);
    check({17'h0, count_value}, {17'h0, e});
  endtask

  task automatic trig(input logic [3:0] m);
    @(posedge clk);
    compare_unit_mode_field <= m;
    compare_trigger <= 1'b1;
    @(posedge clk);
    compare_trigger <= 1'b0;
    #1;
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() > 0) begin
        check({pslverr, prdata}, exp_q.pop_front());
      end else begin
        check({pslverr, prdata}, 33'h1FFFFFFFF);
      end
    end
  end

  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    v = 8'($urandom(32'h875D));
    {reset_n, psel, penable, pwrite, compare_trigger, trig_req} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    port_direction = v[1:0];
    compare_value_high = 8'($urandom);
    compare_value_low = 8'($urandom);
    compare_unit_mode_field = 4'h0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_CT, `COUNT_PAIR_CTRL_RESET);
    rd(A_FL, 8'h00);
    rd(A_EN, 8'h00);
    rd(A_PR, 8'h00);
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 8'h1C, 8'h00);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_CT, {5'h00, m[1], m[0], 1'b0});
      settle(1);
      check({31'h0, count_mode}, {31'h0, m[0] ? (m[1] ? count_pair_async_counter
        : count_pair_sync_counter) : count_pair_timer});
    end
    // One edge short of each division must leave the count alone
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, A_CT, {2'h0, p[1:0], 4'h3});
      cnt(16'hFFFF);
      apb(1'b1, A_FL, 8'h00);
      count_pair_ext_clk_i.pulses((1 << p) - 1, 1'b0);
      settle(10);
      cv(16'hFFFF);
      count_pair_ext_clk_i.pulses(1, 1'b0);
      settle(10);
      rd(A_LO, 8'h00);
      rd(A_HI, 8'h00);
      rd(A_FL, 8'h02);
    end
    apb(1'b1, A_CT, 8'h07);
    cnt(16'h0010);
    count_pair_ext_clk_i.pulses(3, 1'b0);
    settle(10);
    cv(16'h0013);
    apb(1'b1, A_AX, 8'h01);
    settle(1);
    check({31'h0, osc_pin_oe_n}, 33'h3);
    count_pair_ext_clk_i.pulses(2, 1'b1);
    settle(10);
    cv(16'h0015);
    apb(1'b1, A_AX, 8'h00);
    settle(1);
    check({31'h0, osc_pin_oe_n}, {31'h0, port_direction});
    apb(1'b1, A_CT, 8'h02);
    count_pair_ext_clk_i.pulses(2, 1'b0);
    settle(10);
    cv(16'h0015);
    apb(1'b1, A_CT, 8'h13);
    cnt(16'h0000);
    count_pair_ext_clk_i.pulses(1, 1'b0);
    settle(10);
    cnt(16'h0100);
    count_pair_ext_clk_i.pulses(1, 1'b0);
    settle(10);
    cv(16'h0100);
    rd(A_FL, 8'h02);
    settle(1);
    check({32'h0, overflow_irq}, 33'h0);
    apb(1'b1, A_EN, 8'h02);
    apb(1'b1, A_PR, 8'h02);
    settle(1);
    check({31'h0, overflow_irq, overflow_irq_high_prio}, 33'h3);
    apb(1'b1, A_FL, 8'h00);
    settle(1);
    check({31'h0, overflow_irq, overflow_irq_high_prio}, 33'h0);
    // Timer mode held still so the count cannot move under the checks
    apb(1'b1, A_CT, 8'h00);
    cnt(16'($urandom) | 16'h0001);
    trig(`COUNT_PAIR_TRIG_MODE);
    cv(16'h0000);
    rd(A_FL, 8'h00);
    cnt(16'h1234);
    trig(4'hA);
    cv(16'h1234);
    compare_unit_mode_field <= `COUNT_PAIR_TRIG_MODE;
    trig_req = 1'b1;
    apb(1'b1, A_LO, 8'h55);
    trig_req = 1'b0;
    settle(1);
    cv(16'h1255);
    apb(1'b1, A_CT, 8'h82);
    apb(1'b1, A_HI, 8'h9A);
    settle(1);
    cv(16'h1255);
    apb(1'b1, A_LO, 8'h34);
    settle(1);
    cv(16'h9A34);
    rd(A_LO, 8'h34);
    rd(A_HI, 8'h9A);
    apb(1'b1, A_CT, 8'h02);
    apb(1'b1, A_HI, 8'h5C);
    settle(1);
    cv(16'h5C34);
    apb(1'b1, A_CT, 8'h01);
    settle(1);
    v = count_value[7:0];
    settle(40);
    check({25'h0, 8'(count_value[7:0] - v)}, 33'h0A);
    settle(2);
    check({1'b0, 32'(exp_q.size())}, 33'h0);
    test_done();
  end
endmodule // count_pair_top_tb

// ### rtl/count_pair_consts.svh
// Offsets, field positions, reset values and timing counts of the timer.
// Assumes byte addresses on an 8-bit APB address bus, one word per register.
`ifndef COUNT_PAIR_CONSTS_SVH
`define COUNT_PAIR_CONSTS_SVH

// ***************************************
// Register byte offsets
// ***************************************
`define COUNT_PAIR_OFS_CTRL 8'h00
`define COUNT_PAIR_OFS_CNT_LO 8'h04
`define COUNT_PAIR_OFS_CNT_HI 8'h08
`define COUNT_PAIR_OFS_FLAGS 8'h0C
`define COUNT_PAIR_OFS_ENABLES 8'h10
`define COUNT_PAIR_OFS_PRIO 8'h14
`define COUNT_PAIR_OFS_AUX 8'h18

// ***************************************
// Control register fields
// ***************************************
`define COUNT_PAIR_CTRL_WIDE 7
`define COUNT_PAIR_CTRL_PS_HI 5
`define COUNT_PAIR_CTRL_PS_LO 4
`define COUNT_PAIR_CTRL_SYNC 2
`define COUNT_PAIR_CTRL_CS 1
`define COUNT_PAIR_CTRL_RUN 0
`define COUNT_PAIR_CTRL_RESET 8'h00

// ***************************************
// Interrupt and auxiliary registers
// ***************************************
`define COUNT_PAIR_OVF_BIT 1
`define COUNT_PAIR_INT_MASK 8'h4F
`define COUNT_PAIR_INT_RESET 8'h00
`define COUNT_PAIR_AUX_OSC_BIT 0
`define COUNT_PAIR_AUX_MASK 8'h01

// ***************************************
// Counting constants
// ***************************************
`define COUNT_PAIR_CNT_MAX 16'hFFFF
`define COUNT_PAIR_CNT_ZERO 16'h0000
`define COUNT_PAIR_TRIG_MODE 4'hB
`define COUNT_PAIR_CLKS_PER_INSN 2'h3

`endif

// ### rtl/count_pair_pkg.sv
// Types shared by the timer files.
// Assumes the constants header is compiled alongside.
package count_pair_pkg;
  typedef enum logic [1:0] {
    count_pair_timer,
    count_pair_sync_counter,
    count_pair_async_counter
  } count_pair_mode_type;
endpackage

// ### rtl/count_pair_prescale.sv
// Input prescaler of the timer: passes 1 of 1, 2, 4 or 8 ticks.
// Assumes ticks are one-cycle pulses on clk.
`timescale 1ns/1ps
module count_pair_prescale (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [1:0] sel,
  // Ticks
  input wire logic tick_in,
  output logic tick_out
);
  import count_pair_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] mask;

  // 00 -> 1:1, 01 -> 1:2, 10 -> 1:4, 11 -> 1:8
  assign mask = 3'((4'h1 << sel) - 4'h1);
  assign tick_out = tick_in && ((cnt_q & mask) == mask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (clear) begin
      cnt_q <= 3'h0;
    end else if (tick_in) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_presc_clear: assert property (clear |=> cnt_q == 3'h0)
    else $error("prescaler not cleared");
  chk_presc_ratio: assert property (
    tick_out |-> tick_in && (sel == 2'h0 || cnt_q[0])
      && (sel < 2'h2 || cnt_q[1]) && (sel != 2'h3 || cnt_q[2]))
    else $error("prescaler passed a tick early");
endmodule // count_pair_prescale

// ### rtl/count_pair_top.sv
// Sixteen-bit timer/counter with APB register access.
// Assumes the compare unit's trigger is synchronous to clk; count pins pass a two-flop synchroniser unless bypassed.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "count_pair_consts.svh"

module count_pair_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count clock pins
  input wire logic ext_count_input,
  input wire logic aux_osc_clk,
  input wire logic [1:0] port_direction,
  output logic [1:0] osc_pin_oe_n,
  // Compare unit one
  input wire logic [3:0] compare_unit_mode_field,
  input wire logic compare_trigger,
  input wire logic [7:0] compare_value_high,
  input wire logic [7:0] compare_value_low,
  // Status
  output count_pair_pkg::count_pair_mode_type count_mode,
  output logic [15:0] count_value,
  output logic overflow_irq,
  output logic overflow_irq_high_prio
);
  import count_pair_pkg::*;

  // ***************************************
  // Reset release
  // ***************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ***************************************
  // Bus decode
  // ***************************************
  logic [7:0] ctrl_q;
  logic [7:0] flags_q;
  logic [7:0] enables_q;
  logic [7:0] prio_q;
  logic [7:0] aux_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [7:0] hbuf_q;
  logic [31:0] prdata_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire mapped = hit(paddr, `COUNT_PAIR_OFS_CTRL) || hit(paddr, `COUNT_PAIR_OFS_CNT_LO)
    || hit(paddr, `COUNT_PAIR_OFS_CNT_HI) || hit(paddr, `COUNT_PAIR_OFS_FLAGS)
    || hit(paddr, `COUNT_PAIR_OFS_ENABLES) || hit(paddr, `COUNT_PAIR_OFS_PRIO)
    || hit(paddr, `COUNT_PAIR_OFS_AUX);
  wire wr_ctrl = wr && hit(paddr, `COUNT_PAIR_OFS_CTRL);
  wire wr_lo = wr && hit(paddr, `COUNT_PAIR_OFS_CNT_LO);
  wire wr_hi = wr && hit(paddr, `COUNT_PAIR_OFS_CNT_HI);
  wire wr_flags = wr && hit(paddr, `COUNT_PAIR_OFS_FLAGS);
  wire wr_en = wr && hit(paddr, `COUNT_PAIR_OFS_ENABLES);
  wire wr_prio = wr && hit(paddr, `COUNT_PAIR_OFS_PRIO);
  wire wr_aux = wr && hit(paddr, `COUNT_PAIR_OFS_AUX);
  wire rd_lo = rd && hit(paddr, `COUNT_PAIR_OFS_CNT_LO);
  wire [7:0] wbyte = pwdata[7:0];

  // ***************************************
  // Control fields
  // ***************************************
  wire wide = ctrl_q[`COUNT_PAIR_CTRL_WIDE];
  wire run = ctrl_q[`COUNT_PAIR_CTRL_RUN];
  wire ext_sel = ctrl_q[`COUNT_PAIR_CTRL_CS];
  wire no_sync = ctrl_q[`COUNT_PAIR_CTRL_SYNC];
  wire [1:0] ps_sel = ctrl_q[`COUNT_PAIR_CTRL_PS_HI:`COUNT_PAIR_CTRL_PS_LO];
  wire aux_osc_enable = aux_q[`COUNT_PAIR_AUX_OSC_BIT];

  // Sync bit has no meaning under the internal clock
  assign count_mode = !ext_sel ? count_pair_timer
    : (no_sync ? count_pair_async_counter : count_pair_sync_counter);

  // Oscillator pins become inputs regardless of port direction
  assign osc_pin_oe_n = aux_osc_enable ? 2'b11 : port_direction;

  // ***************************************
  // Instruction-cycle enable
  // ***************************************
  logic [1:0] insn_div_q;
  wire insn_tick = (insn_div_q == `COUNT_PAIR_CLKS_PER_INSN);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      insn_div_q <= 2'h0;
    end else begin
      insn_div_q <= insn_div_q + 2'h1;
    end
  end

  // ***************************************
  // External edge detection
  // ***************************************
  logic ext_meta_q;
  logic ext_sync_q;
  logic ext_prev_q;
  logic ext_armed_q;
  wire ext_raw = aux_osc_enable ? aux_osc_clk : ext_count_input;
  // Bypass trades jitter safety for two fewer cycles of latency
  wire ext_level = no_sync ? ext_raw : ext_sync_q;
  // First counted edge must follow a low level seen on the line after reset
  wire ext_edge = ext_level && !ext_prev_q && ext_armed_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      ext_armed_q <= 1'b0;
    end else begin
      ext_meta_q <= ext_raw;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_level;
      if (!ext_level) begin
        ext_armed_q <= 1'b1;
      end
    end
  end

  // ***************************************
  // Counter
  // ***************************************
  wire src_tick = ext_sel ? ext_edge : insn_tick;
  wire cnt_wr = wr_lo || (wr_hi && !wide);
  // Compare unit trigger in the matching mode clears the count and prescaler
  wire trig_hit = compare_trigger
    && (compare_unit_mode_field == `COUNT_PAIR_TRIG_MODE);
  wire presc_clear = cnt_wr || trig_hit;
  wire inc;
  wire ovf = inc && (count_q == `COUNT_PAIR_CNT_MAX);

  count_pair_prescale u_prescale (
    .clk(clk),
    .rst_n(rst_n_q),
    .clear(presc_clear),
    .sel(ps_sel),
    .tick_in(src_tick && run),
    .tick_out(inc)
  );

  always_comb begin
    count_d = count_q;
    if (wr_lo) begin
      // Wide mode loads the buffered high byte with the low byte
      count_d = wide ? {hbuf_q, wbyte} : {count_q[15:8], wbyte};
    end else if (wr_hi && !wide) begin
      count_d = {wbyte, count_q[7:0]};
    end else if (trig_hit) begin
      count_d = `COUNT_PAIR_CNT_ZERO;
    end else if (inc) begin
      count_d = count_q + 16'h0001;
    end
  end

  // Zero at reset keeps checks free of unknowns; software still loads it
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= `COUNT_PAIR_CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // ***************************************
  // Register file
  // ***************************************
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q <= `COUNT_PAIR_CTRL_RESET;
      enables_q <= `COUNT_PAIR_INT_RESET;
      prio_q <= `COUNT_PAIR_INT_RESET;
      aux_q <= 8'h00;
      hbuf_q <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wbyte;
      end
      if (wr_en) begin
        enables_q <= wbyte & `COUNT_PAIR_INT_MASK;
      end
      if (wr_prio) begin
        prio_q <= wbyte & `COUNT_PAIR_INT_MASK;
      end
      if (wr_aux) begin
        aux_q <= wbyte & `COUNT_PAIR_AUX_MASK;
      end
      if (rd_lo && wide) begin
        hbuf_q <= count_q[15:8];
      end else if (wr_hi && wide) begin
        hbuf_q <= wbyte;
      end
    end
  end

  // Rollover set wins over a same-cycle software clear
  logic [7:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = wbyte & `COUNT_PAIR_INT_MASK;
    end
    if (ovf) begin
      flags_d[`COUNT_PAIR_OVF_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      flags_q <= `COUNT_PAIR_INT_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  wire ovf_req = flags_q[`COUNT_PAIR_OVF_BIT] && enables_q[`COUNT_PAIR_OVF_BIT];
  assign overflow_irq = ovf_req;
  assign overflow_irq_high_prio = ovf_req && prio_q[`COUNT_PAIR_OVF_BIT];
  assign count_value = count_q;

  // ***************************************
  // Read data
  // ***************************************
  // High byte in wide mode reads the buffer, not the live count
  wire [7:0] rd_hi_byte = wide ? hbuf_q : count_q[15:8];
  wire [7:0] rd_byte =
      hit(paddr, `COUNT_PAIR_OFS_CTRL) ? ctrl_q
    : hit(paddr, `COUNT_PAIR_OFS_CNT_LO) ? count_q[7:0]
    : hit(paddr, `COUNT_PAIR_OFS_CNT_HI) ? rd_hi_byte
    : hit(paddr, `COUNT_PAIR_OFS_FLAGS) ? flags_q
    : hit(paddr, `COUNT_PAIR_OFS_ENABLES) ? enables_q
    : hit(paddr, `COUNT_PAIR_OFS_PRIO) ? prio_q
    : hit(paddr, `COUNT_PAIR_OFS_AUX) ? aux_q
    : 8'h00;

  // Sampled in setup; the buffered high byte is taken one cycle later, in the access phase of the low-byte read
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prdata_q <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ***************************************
  // Checks
  // ***************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  chk_run_stop: assert property (
    !run && !cnt_wr && !trig_hit |=> count_q == $past(count_q))
    else $error("count moved while stopped");
  chk_wrap_flag: assert property (
    ovf && !cnt_wr && !trig_hit
      |=> count_q == `COUNT_PAIR_CNT_ZERO && flags_q[`COUNT_PAIR_OVF_BIT])
    else $error("rollover did not wrap and flag");
  chk_trig_clear: assert property (
    trig_hit && !cnt_wr |=> count_q == `COUNT_PAIR_CNT_ZERO)
    else $error("trigger did not clear count");
  chk_trig_noflag: assert property (
    trig_hit && !cnt_wr && !flags_q[`COUNT_PAIR_OVF_BIT] && !wr_flags
      |=> !flags_q[`COUNT_PAIR_OVF_BIT])
    else $error("trigger clear raised overflow flag");
  chk_write_wins: assert property (
    trig_hit && wr_lo && !wide |=> count_q[7:0] == $past(wbyte))
    else $error("trigger overrode software write");
  chk_flag_sticky: assert property (
    flags_q[`COUNT_PAIR_OVF_BIT] && !wr_flags |=> flags_q[`COUNT_PAIR_OVF_BIT])
    else $error("overflow flag dropped without clear");
  chk_irq_gate: assert property (
    !enables_q[`COUNT_PAIR_OVF_BIT] |-> !overflow_irq && !overflow_irq_high_prio)
    else $error("request not gated by enable");
  chk_wide_buffer: assert property (
    rd_lo && wide && !wr_hi |=> hbuf_q == $past(count_q[15:8]))
    else $error("high byte not buffered");
  chk_osc_pins: assert property (
    aux_osc_enable |-> osc_pin_oe_n == 2'b11)
    else $error("oscillator pins not inputs");
endmodule // count_pair_top
